// File: sim/tb_top.sv
// Self-checking bench for the instruction cycle cost calculator
`timescale 1ns/1ps
module tb_top;
    logic clk, reset_n, desc_valid, ea1_flag, ea2_flag, imm_has_own;
    logic string_move, float_long, result_valid;
    logic [3:0] mode1, base1, bus_access_count1, sized_xfer_count;
    logic [3:0] mode2, base2, bus_access_count2;
    logic [1:0] scale1, access1, scale2, access2, op_len, flush_kind;
    logic [1:0] int_len, float_weight;
    logic [7:0] wait_states1, wait_states2, len_entry, string_write_waits;
    logic [15:0] internal_cycles, internal_cycles_imm, fetch_time;
    logic [15:0] string_writes, address_calc_cost1, address_calc_cost2;
    logic [15:0] sized_xfer_cost, eff_internal_cycles, total_exec_cycles;
    logic [15:0] float_xfer_cost, integer_xfer_cost;
    int error_cnt = 0;
    int checks_done = 0;

    iccm_core u_dut (.clk, .reset_n, .desc_valid, .ea1_flag, .mode1, .base1,
        .scale1, .access1, .bus_access_count1, .wait_states1, .ea2_flag,
        .mode2, .base2, .scale2, .access2, .bus_access_count2, .wait_states2,
        .op_len, .sized_xfer_count, .len_entry, .internal_cycles,
        .internal_cycles_imm, .imm_has_own, .flush_kind, .fetch_time,
        .string_move, .string_write_waits, .string_writes, .float_long,
        .int_len, .address_calc_cost1, .address_calc_cost2, .sized_xfer_cost,
        .eff_internal_cycles, .total_exec_cycles, .float_weight,
        .float_xfer_cost, .integer_xfer_cost, .result_valid);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] dx(logic [3:0] n, logic [7:0] w);
        return 16'h0004 * n - 16'h0001 + w;
    endfunction

    function automatic logic [15:0] eb(logic [3:0] m, logic [1:0] a,
        logic [3:0] n, logic [7:0] w);
        case (m)
            4'h0, 4'h1: return 16'h0004;
            4'h2: return 16'h0002;
            4'h5: return 16'h0007 + dx(n, w);
            4'h6: return 16'h000B + 16'h0002 * dx(n, w);
            4'h7: return a == 2'h1 ? 16'h0004 :
                a == 2'h0 ? 16'h0002 : 16'h0003;
            default: return 16'h0005;
        endcase
    endfunction

    function automatic logic [15:0] ea(logic f, logic [3:0] m, b,
        logic [1:0] s, a, logic [3:0] n, logic [7:0] w);
        logic [15:0] t;
        if (!f) return 16'h0000;
        if (m != 4'h8) return eb(m, a, n, w);
        t = b == 4'h2 ? 16'h0005 : b == 4'h7 ? 16'h0004 : eb(b, a, n, w);
        return t + (s == 2'h0 ? 16'h0005 : s == 2'h1 ? 16'h0007 :
            s == 2'h2 ? 16'h0008 : 16'h000A);
    endfunction

    function automatic logic [15:0] xf(logic [3:0] m, n, logic [7:0] w);
        if (m == 4'h0 || m == 4'h2) return 16'h0000;
        return op_len == 2'h0 ? 16'h0003 + w : dx(n, w);
    endfunction

    function automatic logic [15:0] ic();
        logic [15:0] t, h, lim;
        t = (imm_has_own && mode1 == 4'h0) ? internal_cycles_imm
            : internal_cycles;
        t = t + len_entry * (op_len == 2'h0 ? 16'h0001 :
            op_len == 2'h1 ? 16'h0002 : 16'h0004);
        if (flush_kind == 2'h1) t = t + 16'h0006 + fetch_time;
        if (flush_kind == 2'h2) t = t + 16'h0005 + fetch_time;
        h = {8'h00, string_write_waits};
        lim = op_len == 2'h2 ? 16'h0004 : 16'h000D;
        if (h > lim) h = lim;
        if (string_move) t = t - h * string_writes;
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic verify();
        logic [15:0] e1, e2, x, i;
        e1 = ea(ea1_flag, mode1, base1, scale1, access1, bus_access_count1,
            wait_states1);
        e2 = ea(ea2_flag, mode2, base2, scale2, access2, bus_access_count2,
            wait_states2);
        x = sized_xfer_count * (xf(mode1, bus_access_count1, wait_states1)
            + xf(mode2, bus_access_count2, wait_states2));
        i = ic();
        chk("result_valid", {15'h0000, result_valid}, 16'h0001);
        chk("addr1", address_calc_cost1, e1);
        chk("addr2", address_calc_cost2, e2);
        chk("xfer", sized_xfer_cost, x);
        chk("internal", eff_internal_cycles, i);
        chk("total", total_exec_cycles, e1 + e2 + x + i);
        chk("fweight", {14'h0000, float_weight},
            float_long ? 16'h0002 : 16'h0001);
        chk("fxfer", float_xfer_cost, 16'h0004);
        chk("ixfer", integer_xfer_cost,
            int_len == 2'h2 ? 16'h0004 : 16'h0002);
    endtask

    // Caller sets inputs at the same edge; one pulse then result check
    task automatic fire();
        desc_valid <= 1'b1;
        @(posedge clk);
        desc_valid <= 1'b0;
        #1;
        verify();
    endtask

    task automatic clr();
        ea1_flag <= 1'b1; mode1 <= 4'h2; base1 <= 4'h2; scale1 <= 2'h0;
        access1 <= 2'h0; bus_access_count1 <= 4'h2; wait_states1 <= 8'h01;
        ea2_flag <= 1'b0; mode2 <= 4'h6; base2 <= 4'h2; scale2 <= 2'h0;
        access2 <= 2'h0; bus_access_count2 <= 4'h2; wait_states2 <= 8'h01;
        op_len <= 2'h0; sized_xfer_count <= 4'h1; len_entry <= 8'h00;
        internal_cycles <= 16'h0004; internal_cycles_imm <= 16'h0009;
        imm_has_own <= 1'b0; flush_kind <= 2'h0; fetch_time <= 16'h0003;
        string_move <= 1'b0; string_write_waits <= 8'h00;
        string_writes <= 16'h0002; float_long <= 1'b0; int_len <= 2'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_addr();
        for (int m = 0; m < 8; m++) begin
            for (int a = 0; a < 3; a++) begin
                @(posedge clk);
                mode1 <= 4'(m);
                access1 <= 2'(a);
                ea2_flag <= 1'b1;
                mode2 <= 4'(m);
                access2 <= 2'(a);
                fire();
            end
        end
        @(posedge clk);
        ea1_flag <= 1'b0;
        fire();
        $display("Test addr done");
    endtask

    task automatic t_scaled();
        logic [3:0] bs [4];
        bs = '{4'h2, 4'h7, 4'h1, 4'h5};
        @(posedge clk);
        clr();
        for (int b = 0; b < 4; b++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge clk);
                ea2_flag <= 1'b1;
                mode2 <= 4'h8;
                base2 <= bs[b];
                scale2 <= 2'(s);
                mode1 <= 4'h8;
                base1 <= bs[b];
                scale1 <= 2'(s);
                fire();
            end
        end
        $display("Test scaled done");
    endtask

    task automatic t_xfer();
        @(posedge clk);
        clr();
        for (int l = 0; l < 3; l++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge clk);
                op_len <= 2'(l);
                mode1 <= k == 3 ? 4'h7 : 4'(k);
                bus_access_count1 <= 4'h3;
                wait_states1 <= 8'h02;
                mode2 <= 4'h3;
                sized_xfer_count <= 4'h2;
                len_entry <= 8'(l + 1);
                fire();
            end
        end
        $display("Test xfer done");
    endtask

    task automatic t_internal();
        @(posedge clk);
        clr();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            mode1 <= k[0] ? 4'h0 : 4'h2;
            imm_has_own <= k[1];
            fire();
        end
        for (int f = 1; f < 3; f++) begin
            @(posedge clk);
            flush_kind <= 2'(f);
            internal_cycles <= 16'h000A;
            fetch_time <= 16'(f + 2);
            fire();
        end
        $display("Test internal done");
    endtask

    // Waits over the hide limit clamp; 13 and 4 sit on the boundary
    task automatic t_string();
        logic [7:0] ws [4];
        ws = '{8'h14, 8'h0D, 8'h06, 8'h04};
        @(posedge clk);
        clr();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            string_move <= 1'b1;
            internal_cycles <= 16'h0064;
            op_len <= k < 2 ? 2'(k) : 2'h2;
            string_write_waits <= ws[k];
            fire();
        end
        $display("Test string done");
    endtask

    task automatic t_copro();
        @(posedge clk);
        clr();
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            float_long <= k[0];
            int_len <= 2'(k / 2);
            fire();
        end
        $display("Test copro done");
    endtask

    task automatic t_hold();
        logic [15:0] t;
        @(posedge clk);
        clr();
        @(posedge clk);
        internal_cycles <= 16'h0020;
        desc_valid <= 1'b1;
        @(posedge clk);
        internal_cycles <= 16'h0030;
        #1;
        chk("first", eff_internal_cycles, 16'h0020);
        @(posedge clk);
        desc_valid <= 1'b0;
        #1;
        verify();
        t = ic();
        repeat (3) begin
            @(posedge clk);
            internal_cycles <= internal_cycles + 16'h0011;
            #1;
            chk("held", eff_internal_cycles, t);
            chk("pulse", {15'h0000, result_valid}, 16'h0000);
        end
        $display("Test hold done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #5000000;
        error_cnt++;
        end_sim();
    end

    initial begin
        reset_n <= 1'b0;
        desc_valid <= 1'b0;
        clr();
        repeat (2) @(posedge clk);
        #1;
        chk("rst_total", total_exec_cycles, 16'h0000);
        chk("rst_fw", {14'h0000, float_weight}, 16'h0001);
        chk("rst_valid", {15'h0000, result_valid}, 16'h0000);
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        $display("Test reset done");
        t_addr();
        t_scaled();
        t_xfer();
        t_internal();
        t_string();
        t_copro();
        t_hold();
        end_sim();
    end
endmodule // tb_top

// File: src/iccm_core.sv
// Cycle cost calculator for one basic instruction descriptor
`timescale 1ns/1ps
// How it works
// - String-move write waits cut internal count; up to 13 byte/word, 4 dword.
// - Transfer costs take wait states already; base figures assume full speed.
// - Address cost: immediate/absolute 4, register 2, relative or space 5.
// - External 11 plus 2 dword costs; memory relative 7 plus one; stack 4/2/3.
// - Scaled index cost is base plus scale; register base 5, stack base 4.
// - Scale cost is 5, 7, 8 or 10 for byte to quad indexing.
// - Byte transfer is 0 for register or immediate, else 3.
// - Word or dword memory transfer is four per bus cycle minus one.
// - Sized transfer picks byte, word or dword cost by length; 0 for register.
// - Length weight is 1, 2 or 4, multiplied by the table entry.
// - Float precision weight is 1 for 32-bit, 2 for 64-bit.
// - Integer coprocessor transfer 2 for byte/word, 4 for dword; float 4.
// - Address cost counts only when the operand's table flag is set.
// - Flushing count is flush point plus 6 or 5, plus fetch time.
// - Fetch time covers next instruction's encoding and index bytes.
// - Immediate operand uses register internal count unless told otherwise.
// - Total is address costs plus transfer costs plus internal count.
module iccm_core (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Descriptor strobe
    input wire logic desc_valid,
    // Operand 1 and 2 addressing
    input wire logic ea1_flag,
    input wire logic [3:0] mode1,
    input wire logic [3:0] base1,
    input wire logic [1:0] scale1,
    input wire logic [1:0] access1,
    input wire logic [3:0] bus_access_count1,
    input wire logic [7:0] wait_states1,
    input wire logic ea2_flag,
    input wire logic [3:0] mode2,
    input wire logic [3:0] base2,
    input wire logic [1:0] scale2,
    input wire logic [1:0] access2,
    input wire logic [3:0] bus_access_count2,
    input wire logic [7:0] wait_states2,
    // Instruction table entries
    input wire logic [1:0] op_len,
    input wire logic [3:0] sized_xfer_count,
    input wire logic [7:0] len_entry,
    input wire logic [15:0] internal_cycles,
    input wire logic [15:0] internal_cycles_imm,
    input wire logic imm_has_own,
    input wire logic [1:0] flush_kind,
    input wire logic [15:0] fetch_time,
    input wire logic string_move,
    input wire logic [7:0] string_write_waits,
    input wire logic [15:0] string_writes,
    // Coprocessor and float
    input wire logic float_long,
    input wire logic [1:0] int_len,
    // Results
    output logic [15:0] address_calc_cost1,
    output logic [15:0] address_calc_cost2,
    output logic [15:0] sized_xfer_cost,
    output logic [15:0] eff_internal_cycles,
    output logic [15:0] total_exec_cycles,
    output logic [1:0] float_weight,
    output logic [15:0] float_xfer_cost,
    output logic [15:0] integer_xfer_cost,
    output logic result_valid
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        iccm_pkg::iccm_state_t st;
        logic [15:0] ea1;
        logic [15:0] ea2;
        logic [15:0] xfer;
        logic [15:0] icyc;
        logic [15:0] total;
        logic [1:0] fw;
        logic [15:0] fx;
        logic [15:0] ix;
        logic vld;
    } iccm_state_s_t;

    iccm_state_s_t s_q;
    iccm_state_s_t s_d;
    logic rst_meta_q;
    logic rst_sync_q;

    // Release of reset through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory transfer cost; wait states ride on top of the full-speed figure
    function automatic logic [15:0] mem_xfer(input logic [1:0] len,
                                             input logic [3:0] bus_access_count,
                                             input logic [7:0] waits);
        logic [15:0] base;
        base = 16'h0000;
        if (len == iccm_pkg::LEN_BYTE) begin
            base = iccm_pkg::XFER_BYTE_MEM;
        end else begin
            base = iccm_pkg::XFER_PER_BUS * {12'h000, bus_access_count}
                   - iccm_pkg::XFER_LESS;
        end
        mem_xfer = base + {8'h00, waits};
    endfunction

    // Operand held in register or immediate needs no transfer
    function automatic logic is_reg_imm(input logic [3:0] mode);
        is_reg_imm = (mode == iccm_pkg::AM_REGISTER) ||
                     (mode == iccm_pkg::AM_IMMEDIATE);
    endfunction

    // Address cost of a plain (non-indexed) mode
    function automatic logic [15:0] plain_ea(input logic [3:0] mode,
                                             input logic [1:0] acc,
                                             input logic [15:0] dxfer);
        case (mode)
            iccm_pkg::AM_IMMEDIATE,
            iccm_pkg::AM_ABSOLUTE: plain_ea = iccm_pkg::EA_IMM_ABS;
            iccm_pkg::AM_REGISTER: plain_ea = iccm_pkg::EA_REGISTER;
            iccm_pkg::AM_REG_REL,
            iccm_pkg::AM_MEM_SPACE: plain_ea = iccm_pkg::EA_REL_SPACE;
            iccm_pkg::AM_EXTERNAL:
                plain_ea = iccm_pkg::EA_EXT_BASE + dxfer + dxfer;
            iccm_pkg::AM_MEM_REL:
                plain_ea = iccm_pkg::EA_MREL_BASE + dxfer;
            iccm_pkg::AM_TOP_STACK: begin
                if (acc == iccm_pkg::AC_WRITE) begin
                    plain_ea = iccm_pkg::EA_TOS_WRITE;
                end else if (acc == iccm_pkg::AC_RMW) begin
                    plain_ea = iccm_pkg::EA_TOS_RMW;
                end else begin
                    plain_ea = iccm_pkg::EA_TOS_READ;
                end
            end
            default: plain_ea = 16'h0000;
        endcase
    endfunction

    // Full address cost, including scaled indexing
    function automatic logic [15:0] ea_cost(input logic flag,
                                            input logic [3:0] mode,
                                            input logic [3:0] base,
                                            input logic [1:0] scale,
                                            input logic [1:0] acc,
                                            input logic [15:0] dxfer);
        logic [15:0] index_base_cost;
        logic [15:0] index_scale_cost;
        index_base_cost = 16'h0000;
        index_scale_cost = 16'h0000;
        if (!flag) begin
            ea_cost = 16'h0000;
        end else if (mode == iccm_pkg::AM_SCALED) begin
            if (base == iccm_pkg::AM_REGISTER) begin
                index_base_cost = iccm_pkg::IDX_BASE_REG;
            end else if (base == iccm_pkg::AM_TOP_STACK) begin
                index_base_cost = iccm_pkg::IDX_BASE_TOS;
            end else begin
                index_base_cost = plain_ea(base, acc, dxfer);
            end
            case (scale)
                iccm_pkg::LEN_BYTE: index_scale_cost = iccm_pkg::IDX_SCALE_B;
                iccm_pkg::LEN_WORD: index_scale_cost = iccm_pkg::IDX_SCALE_W;
                iccm_pkg::LEN_DWORD: index_scale_cost = iccm_pkg::IDX_SCALE_D;
                default: index_scale_cost = iccm_pkg::IDX_SCALE_Q;
            endcase
            ea_cost = index_base_cost + index_scale_cost;
        end else begin
            ea_cost = plain_ea(mode, acc, dxfer);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] dword_xfer_cost1;
    logic [15:0] dword_xfer_cost2;
    logic [15:0] sized1;
    logic [15:0] sized2;
    logic [3:0] weight;
    logic [15:0] base_cyc;
    logic [15:0] hidden;
    logic [7:0] hide_max;

    always_comb begin
        s_d = s_q;
        // Dword cost used for memory relative and external pointer fetches
        dword_xfer_cost1 = mem_xfer(iccm_pkg::LEN_DWORD, bus_access_count1,
                                    wait_states1);
        dword_xfer_cost2 = mem_xfer(iccm_pkg::LEN_DWORD, bus_access_count2,
                                    wait_states2);
        sized1 = is_reg_imm(mode1) ? 16'h0000 :
                 mem_xfer(op_len, bus_access_count1, wait_states1);
        sized2 = is_reg_imm(mode2) ? 16'h0000 :
                 mem_xfer(op_len, bus_access_count2, wait_states2);
        case (op_len)
            iccm_pkg::LEN_BYTE: weight = iccm_pkg::WEIGHT_B;
            iccm_pkg::LEN_WORD: weight = iccm_pkg::WEIGHT_W;
            default: weight = iccm_pkg::WEIGHT_D;
        endcase
        // Immediate shares the register count unless the entry has its own
        base_cyc = (mode1 == iccm_pkg::AM_IMMEDIATE && imm_has_own) ?
                   internal_cycles_imm : internal_cycles;
        // Widened first: 255 times 4 overflows an 8-bit product
        base_cyc = base_cyc + {8'h00, len_entry} * {12'h000, weight};
        case (flush_kind)
            iccm_pkg::FL_ONE_CYCLE:
                base_cyc = base_cyc + iccm_pkg::FLUSH_ONE + fetch_time;
            iccm_pkg::FL_MULTI_CYCLE:
                base_cyc = base_cyc + iccm_pkg::FLUSH_MULTI + fetch_time;
            default: base_cyc = base_cyc;
        endcase
        // Pointer update overlaps the write, hiding a bounded number of waits
        hide_max = (op_len == iccm_pkg::LEN_DWORD) ? iccm_pkg::HIDE_WAIT_D
                                                   : iccm_pkg::HIDE_WAIT_BW;
        hidden = 16'h0000;
        if (string_move) begin
            hidden = 16'((string_write_waits > hide_max ? hide_max
                          : string_write_waits) * string_writes);
        end
        if (hidden > base_cyc) begin
            hidden = base_cyc;
        end
        if (desc_valid) begin
            s_d.ea1 = ea_cost(ea1_flag, mode1, base1, scale1, access1,
                              dword_xfer_cost1);
            s_d.ea2 = ea_cost(ea2_flag, mode2, base2, scale2, access2,
                              dword_xfer_cost2);
            s_d.xfer = 16'(sized_xfer_count * (sized1 + sized2));
            s_d.icyc = base_cyc - hidden;
            s_d.total = s_d.ea1 + s_d.ea2 + s_d.xfer + s_d.icyc;
            s_d.fw = float_long ? iccm_pkg::PREC_LONG
                                : iccm_pkg::PREC_STD;
            s_d.fx = iccm_pkg::FLOAT_XFER;
            s_d.ix = (int_len == iccm_pkg::LEN_DWORD) ?
                     iccm_pkg::INT_XFER_DWORD
                     : iccm_pkg::INT_XFER_SHORT;
            s_d.st = iccm_pkg::ST_HOLD;
        end
        s_d.vld = desc_valid;
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            s_q <= '{st: iccm_pkg::ST_IDLE, fw: iccm_pkg::PREC_STD,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign address_calc_cost1 = s_q.ea1;
    assign address_calc_cost2 = s_q.ea2;
    assign sized_xfer_cost = s_q.xfer;
    assign eff_internal_cycles = s_q.icyc;
    assign total_exec_cycles = s_q.total;
    assign float_weight = s_q.fw;
    assign float_xfer_cost = s_q.fx;
    assign integer_xfer_cost = s_q.ix;
    assign result_valid = s_q.vld;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb_assert @(posedge clk);
    endclocking
    default disable iff (!rst_sync_q);

    sequence desc_in;
        desc_valid;
    endsequence

    a_total_next_cycle: assert property (desc_in |=> result_valid)
        else $error("result not valid after descriptor");
    a_total_holds: assert property (
        !desc_valid |=> $stable(total_exec_cycles))
        else $error("total changed without descriptor");
    a_total_sum: assert property (
        result_valid |-> total_exec_cycles == 16'(address_calc_cost1
        + address_calc_cost2 + sized_xfer_cost + eff_internal_cycles))
        else $error("total is not the sum");
    a_ea_flag_off: assert property (
        desc_valid && !ea1_flag |=> address_calc_cost1 == 16'h0000)
        else $error("address cost counted with flag clear");
    a_ea_register: assert property (
        desc_valid && ea1_flag && mode1 == iccm_pkg::AM_REGISTER
        |=> address_calc_cost1 == 16'h0002)
        else $error("register address cost wrong");
    a_ea_tos_rmw: assert property (
        desc_valid && ea2_flag && mode2 == iccm_pkg::AM_TOP_STACK
        && access2 == iccm_pkg::AC_RMW |=> address_calc_cost2 == 16'h0003)
        else $error("stack rmw address cost wrong");
    a_scaled_quad: assert property (
        desc_valid && ea1_flag && mode1 == iccm_pkg::AM_SCALED
        && base1 == iccm_pkg::AM_REGISTER && scale1 == iccm_pkg::LEN_QUAD
        |=> address_calc_cost1 == 16'h000F)
        else $error("scaled index cost wrong");
    a_reg_no_xfer: assert property (
        desc_valid && is_reg_imm(mode1) && is_reg_imm(mode2)
        |=> sized_xfer_cost == 16'h0000)
        else $error("register operand charged a transfer");
    a_int_xfer_cost: assert property (
        desc_valid && int_len == iccm_pkg::LEN_BYTE
        |=> integer_xfer_cost == 16'h0002)
        else $error("integer transfer cost wrong");
    a_float_weight: assert property (
        desc_valid |=> float_weight == ($past(float_long) ? 2'h2 : 2'h1))
        else $error("float weight wrong");

endmodule // iccm_core

// File: src/iccm_pkg.sv
// Package: constants and types for the instruction cycle cost model
package iccm_pkg;

    // Addressing modes of an operand
    typedef enum logic [3:0] {
        AM_IMMEDIATE = 4'h0,
        AM_ABSOLUTE = 4'h1,
        AM_REGISTER = 4'h2,
        AM_REG_REL = 4'h3,
        AM_MEM_SPACE = 4'h4,
        AM_MEM_REL = 4'h5,
        AM_EXTERNAL = 4'h6,
        AM_TOP_STACK = 4'h7,
        AM_SCALED = 4'h8
    } iccm_mode_t;

    // Access class, for top-of-stack cost
    typedef enum logic [1:0] {
        AC_READ = 2'h0,
        AC_WRITE = 2'h1,
        AC_RMW = 2'h2
    } iccm_access_t;

    // Operand or operation length
    typedef enum logic [1:0] {
        LEN_BYTE = 2'h0,
        LEN_WORD = 2'h1,
        LEN_DWORD = 2'h2,
        LEN_QUAD = 2'h3
    } iccm_len_t;

    // Queue flush handling of the internal count
    typedef enum logic [1:0] {
        FL_NONE = 2'h0,
        FL_ONE_CYCLE = 2'h1,
        FL_MULTI_CYCLE = 2'h2
    } iccm_flush_t;

    // Controller states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } iccm_state_t;

    localparam int COST_W = 16;

    // Address cost figures
    localparam logic [15:0] EA_IMM_ABS = 16'h0004;
    localparam logic [15:0] EA_REGISTER = 16'h0002;
    localparam logic [15:0] EA_REL_SPACE = 16'h0005;
    localparam logic [15:0] EA_EXT_BASE = 16'h000B;
    localparam logic [15:0] EA_MREL_BASE = 16'h0007;
    localparam logic [15:0] EA_TOS_WRITE = 16'h0004;
    localparam logic [15:0] EA_TOS_READ = 16'h0002;
    localparam logic [15:0] EA_TOS_RMW = 16'h0003;
    localparam logic [15:0] IDX_BASE_REG = 16'h0005;
    localparam logic [15:0] IDX_BASE_TOS = 16'h0004;
    localparam logic [15:0] IDX_SCALE_B = 16'h0005;
    localparam logic [15:0] IDX_SCALE_W = 16'h0007;
    localparam logic [15:0] IDX_SCALE_D = 16'h0008;
    localparam logic [15:0] IDX_SCALE_Q = 16'h000A;

    // Operand transfer figures
    localparam logic [15:0] XFER_BYTE_MEM = 16'h0003;
    localparam logic [15:0] XFER_PER_BUS = 16'h0004;
    localparam logic [15:0] XFER_LESS = 16'h0001;

    // Length and precision weights
    localparam logic [3:0] WEIGHT_B = 4'h1;
    localparam logic [3:0] WEIGHT_W = 4'h2;
    localparam logic [3:0] WEIGHT_D = 4'h4;
    localparam logic [1:0] PREC_STD = 2'h1;
    localparam logic [1:0] PREC_LONG = 2'h2;

    // Coprocessor transfer figures
    localparam logic [15:0] INT_XFER_SHORT = 16'h0002;
    localparam logic [15:0] INT_XFER_DWORD = 16'h0004;
    localparam logic [15:0] FLOAT_XFER = 16'h0004;

    // Queue flush and string move figures
    localparam logic [15:0] FLUSH_ONE = 16'h0006;
    localparam logic [15:0] FLUSH_MULTI = 16'h0005;
    localparam logic [7:0] HIDE_WAIT_BW = 8'h0D;
    localparam logic [7:0] HIDE_WAIT_D = 8'h04;

endpackage
